// ===== src/link_tx.sv
// Serial link transmitter: lane framing, alignment sequence and scrambling.
`timescale 1ns/1ps
`include "link_tx_regs.svh"
module link_tx (
    // Device clock and reset.
    input  wire logic                      CLK,
    input  wire logic                      RST,
    // Link pins from the receiver and the timing reference.
    input  wire logic                      SYNC_N,
    input  wire logic                      SYSREF,
    // Configuration.
    input  wire logic                      MODE_64B66B,
    input  wire logic [`LANE_CNT_W-1:0]    LANE_COUNT,
    input  wire logic                      SCRAMBLE_EN,
    input  wire logic                      FEC_EN,
    input  wire logic                      NCO_SYNC_EN,
    input  wire logic [`MF_W-1:0]          MF_PERIOD_M1,
    // Sample stream, one octet per lane per word.
    input  wire logic                      IN_VALID,
    input  wire logic [`LANES*`OCT_W-1:0]  IN_DATA,
    output logic                           IN_READY,
    // Lane characters before line coding.
    output logic [`LANES*`OCT_W-1:0]       LANE_DATA,
    output logic [`LANES-1:0]              LANE_CTRL,
    output logic [1:0]                     LANE_HDR,
    output logic                           LANE_HDR_VALID,
    // Status.
    output logic                           LINK_UP,
    output logic                           LMFC_EDGE,
    output logic                           SYSREF_SHIFT,
    output logic                           NCO_SYNC,
    output logic                           FEC_ACTIVE
);
    localparam int DW = `LANES * `OCT_W;

    stream_if #(.W(DW)) in_if ();
    stream_if #(.W(DW)) rd_if ();

    link_tx_pkg::tx_state_type state_q, state_d;
    logic [2:0]       ilas_q, ilas_d;
    logic [`MF_W-1:0] lmfc_q, lmfc_d;
    logic             sync_meta_q, sync_q, sync_prev_q;
    logic             sref_meta_q, sref_q, sref_prev_q;
    logic             sysref_rise, pop, mf_last;
    logic             shift_q, shift_d, edge_q, edge_d, nco_q, nco_d;
    logic             up_q, up_d, fec_q, fec_d, hdrv_q, hdrv_d;
    logic [1:0]       hdr_q, hdr_d;

    // Self-synchronous scrambler, MSB first; the taps depend on the line coding.
    function automatic logic [`SCR_W+7:0] scramble(input logic [`SCR_W-1:0] s_in,
                                                  input logic [7:0] d, input logic m64);
        logic [`SCR_W-1:0] s;
        logic [7:0]        o;
        logic              fb;
        s = s_in;
        o = 8'h00;
        for (int b = 7; b >= 0; b--) begin
            fb   = m64 ? (s[`SCR66_TAP_A] ^ s[`SCR66_TAP_B]) : (s[`SCR8_TAP_A] ^ s[`SCR8_TAP_B]);
            o[b] = d[b] ^ fb;
            s    = {s[`SCR_W-2:0], o[b]};
        end
        return {s, o};
    endfunction : scramble

    assign in_if.valid = IN_VALID;
    assign in_if.data  = IN_DATA;
    assign IN_READY    = in_if.ready;

    sample_fifo #(.W(DW), .DEPTH(`FIFO_DEPTH)) u_fifo (
        .clk (CLK),
        .rst (RST),
        .wr  (in_if),
        .rd  (rd_if)
    );

    // SYNC is sampled as a level, so both older timing conventions are met.
    // Everything here runs on the single device clock.
    always_ff @(posedge CLK) begin
        if (RST) begin
            sync_meta_q <= 1'b0;
            sync_q      <= 1'b0;
            sync_prev_q <= 1'b0;
            sref_meta_q <= 1'b0;
            sref_q      <= 1'b0;
            sref_prev_q <= 1'b0;
        end else begin
            sync_meta_q <= SYNC_N;
            sync_q      <= sync_meta_q;
            sync_prev_q <= sync_q;
            sref_meta_q <= SYSREF;
            sref_q      <= sref_meta_q;
            sref_prev_q <= sref_q;
        end
    end

    assign sysref_rise = sref_q && !sref_prev_q;
    assign mf_last     = (lmfc_q == MF_PERIOD_M1);

    // Multiframe or extended multiblock counter; SYSREF is always honoured.
    always_comb begin
        lmfc_d  = mf_last ? '0 : lmfc_q + 1'b1;
        shift_d = 1'b0;
        if (sysref_rise) begin
            lmfc_d  = '0;
            shift_d = !mf_last;
        end
        edge_d = (lmfc_d == '0);
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            lmfc_q  <= '0;
            shift_q <= 1'b0;
            edge_q  <= 1'b0;
        end else begin
            lmfc_q  <= lmfc_d;
            shift_q <= shift_d;
            edge_q  <= edge_d;
        end
    end

    // Link start-up. A single state for all lanes keeps them aligned, starting on the multiframe edge that SYSREF sets.
    always_comb begin
        state_d = state_q;
        ilas_d  = ilas_q;
        case (state_q)
            link_tx_pkg::ST_CGS: begin
                if (sync_q) begin
                    state_d = link_tx_pkg::ST_WAIT;
                end
            end
            link_tx_pkg::ST_WAIT: begin
                if (!sync_q) begin
                    state_d = link_tx_pkg::ST_CGS;
                end else if (mf_last) begin
                    state_d = link_tx_pkg::ST_ILAS;
                    ilas_d  = 3'h0;
                end
            end
            link_tx_pkg::ST_ILAS: begin
                if (!sync_q) begin
                    state_d = link_tx_pkg::ST_CGS;
                end else if (mf_last) begin
                    ilas_d = ilas_q + 3'h1;
                    if (ilas_q == `ILAS_LAST) begin
                        state_d = link_tx_pkg::ST_DATA;
                    end
                end
            end
            link_tx_pkg::ST_DATA: begin
                if (!sync_q) begin
                    state_d = link_tx_pkg::ST_CGS;
                end
            end
            link_tx_pkg::ST_BLK: state_d = link_tx_pkg::ST_BLK;
            default: state_d = link_tx_pkg::ST_CGS;
        endcase
        // In block mode the state never looks at SYNC; headers alone give block lock.
        if (MODE_64B66B) begin
            state_d = link_tx_pkg::ST_BLK;
        end else if (state_q == link_tx_pkg::ST_BLK) begin
            state_d = link_tx_pkg::ST_CGS;
        end
        up_d   = (state_d == link_tx_pkg::ST_DATA) || (state_d == link_tx_pkg::ST_BLK);
        fec_d  = MODE_64B66B && FEC_EN;
        nco_d  = MODE_64B66B && NCO_SYNC_EN && sync_prev_q && !sync_q;
        // Only data headers are sent: no check bits and no command channel.
        hdrv_d = (state_q == link_tx_pkg::ST_BLK) && (lmfc_q[2:0] == 3'h0);
        hdr_d  = hdrv_d ? `HDR_DATA : 2'h0;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_q <= link_tx_pkg::ST_CGS;
            ilas_q  <= 3'h0;
            up_q    <= 1'b0;
            fec_q   <= 1'b0;
            nco_q   <= 1'b0;
            hdrv_q  <= 1'b0;
            hdr_q   <= 2'h0;
        end else begin
            state_q <= state_d;
            ilas_q  <= ilas_d;
            up_q    <= up_d;
            fec_q   <= fec_d;
            nco_q   <= nco_d;
            hdrv_q  <= hdrv_d;
            hdr_q   <= hdr_d;
        end
    end

    // The buffer only drains while data flows, so start-up back-pressures the source.
    assign rd_if.ready = (state_q == link_tx_pkg::ST_DATA) || (state_q == link_tx_pkg::ST_BLK);
    assign pop         = rd_if.ready && rd_if.valid;

    for (genvar i = 0; i < `LANES; i++) begin : g_lane
        logic [`SCR_W-1:0]      scr_q, scr_d;
        link_tx_pkg::octet_type oct_q, oct_d;
        logic                   ctl_q, ctl_d;
        link_tx_pkg::octet_type raw;
        logic [`SCR_W+7:0]      sres;

        always_comb begin
            raw   = pop ? rd_if.data[i*`OCT_W +: `OCT_W] : 8'h00;
            sres  = scramble(scr_q, raw, MODE_64B66B);
            scr_d = scr_q;
            oct_d = 8'h00;
            ctl_d = 1'b0;
            if (`LANE_CNT_W'(i) < LANE_COUNT) begin
                case (state_q)
                    link_tx_pkg::ST_CGS, link_tx_pkg::ST_WAIT: begin
                        oct_d = `K28_5;
                        ctl_d = 1'b1;
                    end
                    link_tx_pkg::ST_ILAS: begin
                        // The alignment sequence is never scrambled.
                        if (lmfc_q == '0) begin
                            oct_d = `K28_0;
                            ctl_d = 1'b1;
                        end else if (mf_last) begin
                            oct_d = `K28_3;
                            ctl_d = 1'b1;
                        end else begin
                            oct_d = lmfc_q[7:0];
                        end
                    end
                    link_tx_pkg::ST_DATA: begin
                        if (SCRAMBLE_EN) begin
                            oct_d = sres[7:0];
                            scr_d = sres[`SCR_W+7:8];
                        end else begin
                            oct_d = raw;
                        end
                    end
                    link_tx_pkg::ST_BLK: begin
                        oct_d = sres[7:0];
                        scr_d = sres[`SCR_W+7:8];
                    end
                    default: oct_d = 8'h00;
                endcase
            end
        end

        always_ff @(posedge CLK) begin
            if (RST) begin
                scr_q <= `SCR_SEED;
                oct_q <= 8'h00;
                ctl_q <= 1'b0;
            end else begin
                scr_q <= scr_d;
                oct_q <= oct_d;
                ctl_q <= ctl_d;
            end
        end

        assign LANE_DATA[i*`OCT_W +: `OCT_W] = oct_q;
        assign LANE_CTRL[i]                  = ctl_q;
    end

    assign LANE_HDR       = hdr_q;
    assign LANE_HDR_VALID = hdrv_q;
    assign LINK_UP        = up_q;
    assign LMFC_EDGE      = edge_q;
    assign SYSREF_SHIFT   = shift_q;
    assign NCO_SYNC       = nco_q;
    assign FEC_ACTIVE     = fec_q;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    chk_cgs_comma: assert property (
        state_q == link_tx_pkg::ST_CGS && LANE_COUNT != '0 |=>
        LANE_DATA[7:0] == `K28_5 && LANE_CTRL[0])
        else $error("comma missing during code group sync");
    chk_wait_edge: assert property (
        state_q == link_tx_pkg::ST_WAIT && sync_q && !MODE_64B66B && mf_last && !sysref_rise
        |=> state_q == link_tx_pkg::ST_ILAS && lmfc_q == '0)
        else $error("alignment did not start on the multiframe edge");
    chk_wait_hold: assert property (
        state_q == link_tx_pkg::ST_WAIT && !mf_last |=> state_q != link_tx_pkg::ST_ILAS)
        else $error("alignment started off the multiframe edge");
    chk_ilas_start: assert property (
        state_q == link_tx_pkg::ST_ILAS && lmfc_q == '0 && LANE_COUNT != '0 |=>
        LANE_DATA[7:0] == `K28_0 && LANE_CTRL[0])
        else $error("multiframe did not open with K28.0");
    chk_ilas_end: assert property (
        state_q == link_tx_pkg::ST_ILAS && mf_last && lmfc_q != '0 && LANE_COUNT != '0 |=>
        LANE_DATA[7:0] == `K28_3 && LANE_CTRL[0])
        else $error("multiframe did not close with K28.3");
    chk_ilas_length: assert property (
        state_q == link_tx_pkg::ST_DATA && $past(state_q) == link_tx_pkg::ST_ILAS |->
        $past(ilas_q) == `ILAS_LAST && $past(mf_last))
        else $error("alignment sequence length is not four multiframes");
    chk_blk_sync: assert property (
        state_q == link_tx_pkg::ST_BLK && MODE_64B66B |=> state_q == link_tx_pkg::ST_BLK)
        else $error("block mode left because of sync");
    chk_sysref_zero: assert property (
        sysref_rise |=> lmfc_q == '0 ##1 lmfc_q == `MF_W'(1) || MF_PERIOD_M1 == '0 || sysref_rise)
        else $error("counter not reset by sysref");
    chk_sysref_quiet: assert property (
        sysref_rise |=> SYSREF_SHIFT == !$past(mf_last))
        else $error("sysref shift flag wrong");
    chk_blk_header: assert property (
        state_q == link_tx_pkg::ST_BLK && lmfc_q[2:0] == 3'h0 |=>
        LANE_HDR_VALID && LANE_HDR == `HDR_DATA)
        else $error("sync header missing at block start");
    chk_nco_trigger: assert property (
        MODE_64B66B && NCO_SYNC_EN && $fell(sync_q) |=> NCO_SYNC)
        else $error("oscillator sync trigger missing");
    chk_lane_off: assert property (
        (LANE_CTRL >> LANE_COUNT) == '0 && (LANE_DATA >> (`OCT_W * LANE_COUNT)) == '0)
        else $error("disabled lane active");

    cov_cgs_exit: cover property (state_q == link_tx_pkg::ST_CGS ##1 state_q == link_tx_pkg::ST_WAIT);
    cov_link_up: cover property (state_q == link_tx_pkg::ST_ILAS ##1 state_q == link_tx_pkg::ST_DATA);
    cov_blk_hdr: cover property (LANE_HDR_VALID && pop);
    cov_sref_shift: cover property (SYSREF_SHIFT);
endmodule : link_tx

// ===== inc/link_tx_regs.svh
// Constants of the serial link transmitter: character codes, sizes and scrambler taps.
`ifndef LINK_TX_REGS_SVH
`define LINK_TX_REGS_SVH
`define LANES       16
`define LANE_CNT_W  5
`define OCT_W       8
`define FIFO_DEPTH  16
`define MF_W        10
`define K28_5       8'hbc
`define K28_0       8'h1c
`define K28_3       8'h7c
`define ILAS_LAST   3'h3
`define HDR_DATA    2'h1
`define SCR_W       58
`define SCR_SEED    58'h0
`define SCR8_TAP_A  14
`define SCR8_TAP_B  13
`define SCR66_TAP_A 57
`define SCR66_TAP_B 38
`endif

// ===== inc/link_tx_pkg.sv
// Types shared by the serial link transmitter.
package link_tx_pkg;
    typedef enum logic [2:0] {ST_CGS, ST_WAIT, ST_ILAS, ST_DATA, ST_BLK} tx_state_type;
    typedef logic [7:0] octet_type;
endpackage : link_tx_pkg

// ===== inc/stream_if.sv
// Valid and ready stream between the transmitter and its sample buffer.
`timescale 1ns/1ps
interface stream_if #(parameter int W = 8) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : stream_if

// ===== src/sample_fifo.sv
// Sample buffer with a registered head word; full and empty are honest.
`timescale 1ns/1ps
`include "link_tx_regs.svh"
module sample_fifo #(
    parameter int W     = 128,
    parameter int DEPTH = `FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Fill and drain sides.
    stream_if.snk    wr,
    stream_if.src    rd
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic          full_q, full_d, ov_q, ov_d;
    logic          rdy_q, rdy_d;
    logic [W-1:0]  od_q, od_d;
    logic          push, load, pop_out;

    // Ready has a register of its own, so the source sees it low in reset and never from a gate.
    assign wr.ready = rdy_q;
    assign rd.valid = ov_q;
    assign rd.data  = od_q;

    // The head word sits in a register so the drain side never sees a memory read path.
    always_comb begin
        push    = wr.valid && rdy_q;
        pop_out = ov_q && rd.ready;
        load    = (cnt_q != '0) && (!ov_q || pop_out);
        wp_d    = push ? wp_q + 1'b1 : wp_q;
        rp_d    = load ? rp_q + 1'b1 : rp_q;
        cnt_d   = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
        full_d  = (cnt_d == (AW+1)'(DEPTH));
        rdy_d   = !full_d;
        ov_d    = load || (ov_q && !pop_out);
        od_d    = load ? mem[rp_q] : od_q;
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_q] <= wr.data;
        end
        if (rst) begin
            wp_q   <= '0;
            rp_q   <= '0;
            cnt_q  <= '0;
            full_q <= 1'b0;
            rdy_q  <= 1'b0;
            ov_q   <= 1'b0;
            od_q   <= '0;
        end else begin
            wp_q   <= wp_d;
            rp_q   <= rp_d;
            cnt_q  <= cnt_d;
            full_q <= full_d;
            rdy_q  <= rdy_d;
            ov_q   <= ov_d;
            od_q   <= od_d;
        end
    end

    chk_fifo_full_stop: assert property (@(posedge clk) disable iff (rst)
        full_q |=> cnt_q == (AW+1)'(DEPTH) || $past(load))
        else $error("fifo count moved past full");
endmodule : sample_fifo

// ===== verif/rx_model.sv
// Receiver-side model that requests code group sync and releases it after commas.
`timescale 1ns/1ps
`include "link_tx_regs.svh"
module rx_model (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst,
    // Control from the bench: request link start and extra comma wait.
    input  wire logic       req,
    input  wire logic [7:0] hold,
    // Lane zero characters.
    input  wire logic [7:0] lane_data,
    input  wire logic       lane_ctrl,
    // Sync request, active low.
    output logic            sync_n
);
    logic [8:0] commas_q;
    // A large hold keeps the link in sync on purpose, standing in for a slow receiver.
    always_ff @(posedge clk) begin
        if (rst || !req) begin
            commas_q <= 9'h0;
            sync_n   <= 1'b1;
        end else if (commas_q >= 9'(hold) + 9'h4) begin
            sync_n   <= 1'b1;
        end else begin
            sync_n   <= 1'b0;
            if (lane_ctrl && lane_data == `K28_5)
                commas_q <= commas_q + 9'h1;
            else
                commas_q <= 9'h0;
        end
    end
endmodule : rx_model

// ===== verif/link_tx_tb.sv
// Self-checking bench for the link transmitter.
`timescale 1ns/1ps
`include "link_tx_regs.svh"
module link_tx_tb;
    localparam int NROW = 17;
    logic         clk = 1'b0;
    logic         rst, sync_n, sysref, mode64, scr_en, fec_en, nco_en, in_valid, req;
    logic [4:0]   lane_count;
    logic [9:0]   mf_m1;
    logic [7:0]   hold;
    logic [127:0] in_data, lane_data;
    logic [15:0]  lane_ctrl;
    logic [1:0]   lane_hdr;
    logic         in_ready, hdr_valid, link_up, lmfc_edge, sysref_shift, nco_sync, fec_active;
    logic [127:0] rows_in [NROW];
    logic [127:0] rows_exp [NROW];
    link_tx_pkg::octet_type ilas_oct [8];
    logic         ilas_ctl [8];
    int           err_total, comparisons, k, n, hv;
    logic         seen, mixed, full, prev_edge;

    always #10 clk = ~clk;

    link_tx link_tx_i (.CLK(clk), .RST(rst), .SYNC_N(sync_n), .SYSREF(sysref),
        .MODE_64B66B(mode64), .LANE_COUNT(lane_count), .SCRAMBLE_EN(scr_en),
        .FEC_EN(fec_en), .NCO_SYNC_EN(nco_en), .MF_PERIOD_M1(mf_m1),
        .IN_VALID(in_valid), .IN_DATA(in_data), .IN_READY(in_ready),
        .LANE_DATA(lane_data), .LANE_CTRL(lane_ctrl), .LANE_HDR(lane_hdr),
        .LANE_HDR_VALID(hdr_valid), .LINK_UP(link_up), .LMFC_EDGE(lmfc_edge),
        .SYSREF_SHIFT(sysref_shift), .NCO_SYNC(nco_sync), .FEC_ACTIVE(fec_active));

    rx_model rx_model_i (.clk(clk), .rst(rst), .req(req), .hold(hold),
        .lane_data(lane_data[7:0]), .lane_ctrl(lane_ctrl[0]), .sync_n(sync_n));

    task chk(input logic [127:0] seen_v, input logic [127:0] exp_v);
        comparisons++;
        if (seen_v !== exp_v) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
        end
    endtask : chk

    task end_of_test;
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test

    // A wait that runs out is a hang in the design, so the run stops there.
    task tmo;
        chk(1'b0, 1'b1);
        end_of_test;
    endtask : tmo

    task done_test(input string s);
        $display("test %s done", s);
    endtask : done_test

    task do_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (7) @(posedge clk);
        @(negedge clk);
        chk(in_ready, 1'b0);
        chk(link_up, 1'b0);
        chk(lane_ctrl, 16'h0);
        @(posedge clk);
        rst <= 1'b0;
    endtask : do_reset

    initial begin
        rst = 1'b1; req = 1'b1; hold = 8'h3c; sysref = 1'b0; mode64 = 1'b0;
        lane_count = 5'h10; scr_en = 1'b0; fec_en = 1'b0; nco_en = 1'b0;
        mf_m1 = 10'h7; in_valid = 1'b0; in_data = 128'h0;
        err_total = 0; comparisons = 0;
        for (k = 0; k < NROW; k++) begin
            for (n = 0; n < 16; n++)
                rows_in[k][8*n +: 8] = 8'(k * 16 + n + 1);
            rows_exp[k] = rows_in[k];
        end
        for (k = 0; k < 8; k++) begin
            ilas_oct[k] = (k == 0) ? `K28_0 : ((k == 7) ? `K28_3 : 8'(k));
            ilas_ctl[k] = (k == 0 || k == 7);
        end
        do_reset;
        repeat (4) @(negedge clk);
        repeat (3) begin
            @(negedge clk);
            chk(lane_data, {16{`K28_5}});
            chk(lane_ctrl, 16'hffff);
        end
        done_test("commas");
        // The buffer must hold words while the link is still syncing.
        @(posedge clk);
        in_valid <= 1'b1;
        in_data  <= rows_in[0];
        k = 0; n = 0; full = 1'b0;
        while (!full && n < 40) begin
            @(negedge clk);
            if (in_ready !== 1'b1) full = 1'b1;
            else begin
                @(posedge clk);
                k++;
                in_data <= rows_in[k % NROW];
            end
            n++;
        end
        chk(k, NROW);
        repeat (3) begin
            @(negedge clk);
            chk(in_ready, 1'b0);
        end
        @(posedge clk);
        in_valid <= 1'b0;
        hold     <= 8'h00;
        done_test("fill");
        n = 0; prev_edge = 1'b0;
        while (!(lane_ctrl[0] === 1'b1 && lane_data[7:0] === `K28_0) && n < 200) begin
            prev_edge = lmfc_edge;
            @(negedge clk);
            n++;
        end
        if (n >= 200) tmo;
        chk(prev_edge, 1'b1);
        for (k = 0; k < 32; k++) begin
            chk(lane_data, {16{ilas_oct[k % 8]}});
            chk(lane_ctrl, {16{ilas_ctl[k % 8]}});
            @(negedge clk);
        end
        chk(link_up, 1'b1);
        done_test("ilas");
        n = 0;
        while (lane_data !== rows_in[0] && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (n >= 20) tmo;
        for (k = 0; k < NROW; k++) begin
            chk(lane_data, rows_exp[k]);
            chk(lane_ctrl, 16'h0);
            @(negedge clk);
        end
        done_test("drain");
        // The scrambler state is still zero, so one marked word gives a known pair of octets.
        @(posedge clk);
        scr_en   <= 1'b1;
        in_valid <= 1'b1;
        in_data  <= {16{8'h80}};
        @(posedge clk);
        in_valid <= 1'b0;
        n = 0;
        while (lane_data[7:0] === 8'h00 && n < 10) begin
            @(negedge clk);
            n++;
        end
        if (n >= 10) tmo;
        chk(lane_data, {16{8'h80}});
        @(negedge clk);
        chk(lane_data, {16{8'h03}});
        done_test("scramble");
        n = 0;
        while (lmfc_edge !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (n >= 20) tmo;
        n = 1;
        @(negedge clk);
        while (lmfc_edge !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk(n, 8);
        @(posedge clk);
        sysref <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        sysref <= 1'b0;
        seen = 1'b0;
        repeat (8) begin
            @(negedge clk);
            if (sysref_shift === 1'b1) seen = 1'b1;
        end
        chk(seen, 1'b1);
        repeat (7) @(posedge clk);
        sysref <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        sysref <= 1'b0;
        seen = 1'b0;
        repeat (8) begin
            @(negedge clk);
            if (sysref_shift === 1'b1) seen = 1'b1;
        end
        chk(seen, 1'b0);
        done_test("sysref");
        @(posedge clk);
        req  <= 1'b0;
        hold <= 8'hc8;
        @(posedge clk);
        req <= 1'b1;
        n = 0;
        while (link_up !== 1'b0 && n < 10) begin
            @(negedge clk);
            n++;
        end
        if (n >= 10) tmo;
        repeat (2) @(negedge clk);
        chk(lane_data, {16{`K28_5}});
        chk(lane_ctrl, 16'hffff);
        done_test("resync");
        @(posedge clk);
        rst <= 1'b1; mode64 <= 1'b1; lane_count <= 5'h4; fec_en <= 1'b1; nco_en <= 1'b1;
        do_reset;
        n = 0;
        while (link_up !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        if (n >= 10) tmo;
        chk(fec_active, 1'b1);
        @(posedge clk);
        in_valid <= 1'b1;
        in_data  <= {16{8'hff}};
        repeat (8) @(posedge clk);
        in_valid <= 1'b0;
        hv = 0; mixed = 1'b0;
        repeat (24) begin
            @(negedge clk);
            chk(lane_ctrl, 16'h0);
            chk(lane_data[127:32], 96'h0);
            if (hdr_valid === 1'b1) begin
                hv++;
                chk(lane_hdr, `HDR_DATA);
            end
            if (lane_data[31:0] !== 32'h0 && lane_data[31:0] !== 32'hffffffff) mixed = 1'b1;
        end
        chk(hv, 3);
        chk(mixed, 1'b1);
        @(posedge clk);
        req <= 1'b0;
        repeat (4) @(posedge clk);
        req <= 1'b1;
        seen = 1'b0;
        repeat (10) begin
            @(negedge clk);
            if (nco_sync === 1'b1) seen = 1'b1;
        end
        chk(seen, 1'b1);
        chk(link_up, 1'b1);
        done_test("block");
        end_of_test;
    end
endmodule : link_tx_tb
